// File: verilog/dsr_consts.vh
// Constants for the DMA request scan router: register offsets, fields, resets.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define DSR_OFF_CTRL 8'h00
`define DSR_OFF_BYPASS 8'h04
`define DSR_OFF_IOMAP 8'h08
`define DSR_OFF_STATUS 8'h0C

// ************************************************************
// Control register fields
// ************************************************************
`define DSR_CTRL_LIMA_LSB 0
`define DSR_CTRL_MODEA_BIT 3
`define DSR_CTRL_LIMB_LSB 4
`define DSR_CTRL_MODEB_BIT 7
`define DSR_CTRL_OPC_LSB 8
`define DSR_CTRL_CHAIN_BIT 10
`define DSR_CTRL_WIDTH 11

// ************************************************************
// Status register fields
// ************************************************************
`define DSR_STAT_REQ_LSB 0
`define DSR_STAT_CNTA_LSB 8
`define DSR_STAT_CNTB_LSB 12
`define DSR_STAT_LOCK_BIT 16

// ************************************************************
// Opcodes and reset values
// ************************************************************
`define DSR_OPC_RUN 2'h0
`define DSR_OPC_SET 2'h1
`define DSR_OPC_CLR 2'h2
`define DSR_OPC_CNTCLR 2'h3
`define DSR_CTRL_RST 11'h0
`define DSR_BYPASS_RST 8'h00
`define DSR_IOMAP_RST 8'h00
`define DSR_SYNC_RST 8'hFF

`endif

// File: verilog/dsr_pin_sync.v
// Three-stage pin synchroniser for the eight external request lines.
// Assumes asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
`include "dsr_consts.vh"

module dsr_pin_sync (
    input wire pclk,
    input wire presetn,
    input wire [7:0] pin_in,
    output wire [7:0] level_out
);

    reg [7:0] s1_reg;
    reg [7:0] s2_reg;
    reg [7:0] s3_reg;
    reg [7:0] level_reg;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_reg[i] <= 1'b1;
                    s2_reg[i] <= 1'b1;
                    s3_reg[i] <= 1'b1;
                    level_reg[i] <= 1'b1;
                end else begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        level_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign level_out = level_reg;

endmodule // dsr_pin_sync

`default_nettype wire

// File: verilog/dsr_scan_counter.v
// Three-bit scan counter of one scan circuit with wrap at a limit.
// Assumes advance is a single-cycle pulse on pclk; clear is a level held while the clear command stays in the control register and the limit is zero.
`timescale 1ns/1ps
`default_nettype none
`include "dsr_consts.vh"

module dsr_scan_counter (
    input wire pclk,
    input wire presetn,
    input wire advance,
    input wire clear,
    input wire [2:0] limit,
    output wire [2:0] count
);

    reg [2:0] count_reg;
    reg [2:0] count_next;

    always @* begin
        count_next = count_reg;
        if (clear) begin
            count_next = 3'h0;
        end else if (advance) begin
            if (count_reg >= limit) begin
                count_next = 3'h0;
            end else begin
                count_next = count_reg + 3'h1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 3'h0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule // dsr_scan_counter

`default_nettype wire

// File: verilog/dsr_router.v
// Top of the DMA request scan router: APB registers, two scan circuits, outputs.
// Assumes ctrl_service comes from controller logic on pclk; request pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "dsr_consts.vh"

module dsr_router (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] ext_dma_request_n,
    input wire [7:0] ctrl_service,
    output wire [7:0] ctrl_request,
    output wire bus_lock
);

    // ************************************************************
    // Registers
    // ************************************************************
    reg [10:0] ctrl_reg;
    reg [7:0] bypass_reg;
    reg [7:0] iomap_reg;
    reg [7:0] flag_reg;
    reg [7:0] flag_next;
    reg [7:0] req_prev_reg;
    reg trig_b_prev_reg;
    reg [7:0] ctrl_request_reg;
    reg bus_lock_reg;

    wire [7:0] req_lvl_n;
    wire [7:0] req_lvl;
    wire [7:0] req_rise;
    wire [2:0] wrap_select_low_group;
    wire [2:0] wrap_select_high_group;
    wire mode_a;
    wire mode_b;
    wire [1:0] opcode;
    wire chain_enable;
    wire run;
    wire trig_b;
    wire trig_a_rise;
    wire trig_b_rise;
    wire [2:0] count_a;
    wire [2:0] count_b;
    wire wr_en;
    wire rd_setup;
    wire addr_hit;

    // ************************************************************
    // Control field decode
    // ************************************************************
    assign wrap_select_low_group = ctrl_reg[`DSR_CTRL_LIMA_LSB +: 3];
    assign wrap_select_high_group = ctrl_reg[`DSR_CTRL_LIMB_LSB +: 3];
    assign mode_a = ctrl_reg[`DSR_CTRL_MODEA_BIT];
    assign mode_b = ctrl_reg[`DSR_CTRL_MODEB_BIT];
    assign opcode = ctrl_reg[`DSR_CTRL_OPC_LSB +: 2];
    assign chain_enable = ctrl_reg[`DSR_CTRL_CHAIN_BIT];
    assign run = (opcode == `DSR_OPC_RUN);

    // ************************************************************
    // APB slave
    // ************************************************************
    assign addr_hit = (paddr == `DSR_OFF_CTRL) || (paddr == `DSR_OFF_BYPASS) ||
                      (paddr == `DSR_OFF_IOMAP) || (paddr == `DSR_OFF_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `DSR_CTRL_RST;
            bypass_reg <= `DSR_BYPASS_RST;
            iomap_reg <= `DSR_IOMAP_RST;
        end else if (wr_en) begin
            if (paddr == `DSR_OFF_CTRL) begin
                ctrl_reg <= pwdata[10:0];
            end
            if (paddr == `DSR_OFF_BYPASS) begin
                bypass_reg <= pwdata[7:0];
            end
            if (paddr == `DSR_OFF_IOMAP) begin
                iomap_reg <= pwdata[7:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `DSR_OFF_CTRL: begin
                    prdata <= {21'h0, ctrl_reg};
                end
                `DSR_OFF_BYPASS: begin
                    prdata <= {24'h000000, bypass_reg};
                end
                `DSR_OFF_IOMAP: begin
                    prdata <= {24'h000000, iomap_reg};
                end
                `DSR_OFF_STATUS: begin
                    prdata <= {15'h0, bus_lock_reg, 1'b0, count_b, 1'b0, count_a,
                               ctrl_request_reg};
                end
                default: begin
                    prdata <= 32'h00000000;
                end
            endcase
        end
    end

    // ************************************************************
    // Request inputs and triggers
    // ************************************************************
    dsr_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ext_dma_request_n),
        .level_out(req_lvl_n)
    );

    assign req_lvl = ~req_lvl_n;
    assign req_rise = req_lvl & ~req_prev_reg;
    assign trig_b = chain_enable ? req_lvl[0] : req_lvl[4];
    assign trig_a_rise = req_rise[0];
    assign trig_b_rise = trig_b && !trig_b_prev_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev_reg <= 8'h00;
            trig_b_prev_reg <= 1'b0;
        end else begin
            req_prev_reg <= req_lvl;
            trig_b_prev_reg <= trig_b;
        end
    end

    // ************************************************************
    // Scan counters
    // ************************************************************
    dsr_scan_counter u_cnt_a (
        .pclk(pclk),
        .presetn(presetn),
        .advance(run && !mode_a && trig_a_rise),
        .clear((opcode == `DSR_OPC_CNTCLR) && (wrap_select_low_group == 3'h0)),
        .limit(wrap_select_low_group),
        .count(count_a)
    );

    dsr_scan_counter u_cnt_b (
        .pclk(pclk),
        .presetn(presetn),
        .advance(run && !mode_b && trig_b_rise),
        .clear((opcode == `DSR_OPC_CNTCLR) && (wrap_select_high_group == 3'h0)),
        .limit(wrap_select_high_group),
        .count(count_b)
    );

    // ************************************************************
    // Per-channel request flags
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_ch
            wire [31:0] idx;
            wire own_ok;
            wire hi;
            wire [1:0] j;
            wire [2:0] lim;
            wire md;
            wire [2:0] cnt;
            wire trig_rise;
            wire trig_lvl;
            wire cyc_hit;
            wire par_hit;
            wire scan_set;
            wire cmd_hit;
            wire src;
            wire drop;
            wire set_any;
            wire clr_any;

            assign idx = i;
            assign hi = idx[2];
            assign j = idx[1:0];
            assign lim = hi ? wrap_select_high_group : wrap_select_low_group;
            assign md = hi ? mode_b : mode_a;
            assign cnt = hi ? count_b : count_a;
            assign trig_rise = hi ? trig_b_rise : trig_a_rise;
            assign trig_lvl = hi ? trig_b : req_lvl[0];
            // In chained cyclic scans circuit B owns counter positions 4 to 7.
            assign cyc_hit = (cnt[2] == (hi && chain_enable)) && (cnt[1:0] == j);
            assign par_hit = ({1'b0, j} <= lim);
            // The trigger pin of a scanning circuit reaches its lines only through the scan.
            assign own_ok = (j != 2'h0) || (lim == 3'h0);
            assign scan_set = run && ((req_rise[i] && own_ok) ||
                              (trig_rise && (md ? par_hit : cyc_hit)));
            assign cmd_hit = (lim[2] == hi) && (lim[1:0] == j);
            assign src = (lim != 3'h0) ? trig_lvl : req_lvl[i];
            assign drop = (!md && !src) || (iomap_reg[i] && ctrl_service[i]);
            assign set_any = scan_set || ((opcode == `DSR_OPC_SET) && cmd_hit);
            assign clr_any = drop || ((opcode == `DSR_OPC_CLR) && cmd_hit);

            always @* begin
                if (set_any) begin
                    flag_next[i] = 1'b1;
                end else if (clr_any) begin
                    flag_next[i] = 1'b0;
                end else begin
                    flag_next[i] = flag_reg[i];
                end
            end

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_reg[i] <= 1'b0;
                    ctrl_request_reg[i] <= 1'b0;
                end else begin
                    flag_reg[i] <= flag_next[i];
                    ctrl_request_reg[i] <= bypass_reg[i] ? req_lvl[i] : flag_next[i];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Bus lock and outputs
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_lock_reg <= 1'b0;
        end else begin
            bus_lock_reg <= !run;
        end
    end

    assign ctrl_request = ctrl_request_reg;
    assign bus_lock = bus_lock_reg;

endmodule // dsr_router

`default_nettype wire

// File: verif/dsr_router_sva.sv
// Concurrent checks on the scan router ports, bound into the top module.
// Assumes an APB master that holds each request until pready is sampled.
`timescale 1ns/1ps
`default_nettype none

module dsr_router_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [7:0] ctrl_request,
    input wire logic bus_lock
);
    logic [10:0] sh_reg;
    logic [7:0] byp;
    wire wr = psel && penable && pwrite;
    wire mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
    wire [1:0] opc = sh_reg[9:8];
    wire [2:0] la = sh_reg[2:0];
    wire [2:0] lb = sh_reg[6:4];

    // Mirrors the control and bypass registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_reg <= 11'h000;
            byp <= 8'h00;
        end else if (wr && paddr == 8'h00) begin
            sh_reg <= pwdata[10:0];
        end else if (wr && paddr == 8'h04) begin
            byp <= pwdata[7:0];
        end
    end

    // ********
    // Checks
    // ********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_quiet: assert property ($rose(presetn) |-> ctrl_request == 8'h00 && !bus_lock)
        else $error("outputs active after reset");
    a_lock_on_write: assert property (
        wr && paddr == 8'h00 && pwdata[9:8] != 2'h0 |-> ##2 bus_lock)
        else $error("no lock after command");
    a_unlock_normal: assert property ((opc == 2'h0) [*3] |-> !bus_lock)
        else $error("lock in normal run");
    a_set_low: assert property (
        (opc == 2'h1 && la < 3'h4 && !byp[la] && $stable(sh_reg)) [*3] |-> ctrl_request[la])
        else $error("low set line not driven");
    a_set_high: assert property (
        (opc == 2'h1 && lb > 3'h3 && !byp[lb] && $stable(sh_reg)) [*3] |-> ctrl_request[lb])
        else $error("high set line not driven");
    a_clr_low: assert property (
        (opc == 2'h2 && la < 3'h4 && !byp[la] && $stable(sh_reg)) [*3] |-> !ctrl_request[la])
        else $error("low clear line still driven");
    a_clr_high: assert property (
        (opc == 2'h2 && lb > 3'h3 && !byp[lb] && $stable(sh_reg)) [*3] |-> !ctrl_request[lb])
        else $error("high clear line still driven");
    a_unmapped_err: assert property (
        psel && penable && !mapped |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not refused");

    c_set: cover property (opc == 2'h1 && ctrl_request != 8'h00);
    c_lock: cover property (bus_lock);
    c_err: cover property (pslverr);
    c_chain_high: cover property (opc == 2'h0 && sh_reg[10] && ctrl_request[7]);
endmodule // dsr_router_sva

bind dsr_router dsr_router_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .ctrl_request(ctrl_request), .bus_lock(bus_lock));

`default_nettype wire

// File: verif/dsr_partner.sv
// Model of the requesting boards and of the controller service strobes.
// Assumes requests are commanded by the bench; service answers in 2 to 4 cycles.
`timescale 1ns/1ps
`default_nettype none

module dsr_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] req_on,
    input wire logic [7:0] io_map,
    input wire logic [7:0] ctrl_request,
    output logic [7:0] ext_dma_request_n,
    output logic [7:0] ctrl_service
);
    logic [2:0] cnt [8];

    // Requests of uncertain length go through the scan path.
    assign ext_dma_request_n = ~req_on;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_service <= 8'h00;
            for (int i = 0; i < 8; i++) cnt[i] <= 3'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                ctrl_service[i] <= 1'b0;
                cnt[i] <= 3'h0;
                if (ctrl_request[i] && io_map[i] && !ctrl_service[i]) begin
                    cnt[i] <= cnt[i] + 3'h1;
                    if (cnt[i] == 3'(1 + i % 3)) begin
                        ctrl_service[i] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // dsr_partner

`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the scan router with APB master tasks.
// Assumes zero or more wait states and the partner model on the request side.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] req_on = 8'h00;
    logic [7:0] io_map = 8'h00;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic bus_lock;
    wire logic [7:0] ext_n;
    wire logic [7:0] serv;
    wire logic [7:0] ctrl_request;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [31:0] d;
    logic e;
    int n;
    logic [2:0] pa [4] = '{3'h7, 3'h7, 3'h7, 3'h0};
    logic [2:0] pb [4] = '{3'h0, 3'h1, 3'h7, 3'h1};
    logic pc [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int pp [4] = '{0, 0, 0, 4};
    logic [7:0] pe [4] = '{8'h1F, 8'h3F, 8'hFF, 8'h30};

    dsr_router dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_dma_request_n(ext_n), .ctrl_service(serv),
        .ctrl_request(ctrl_request), .bus_lock(bus_lock));
    dsr_partner u_far (.pclk(pclk), .presetn(presetn), .req_on(req_on), .io_map(io_map),
        .ctrl_request(ctrl_request), .ext_dma_request_n(ext_n), .ctrl_service(serv));

    initial forever #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    // ********
    // Tasks
    // ********
    function automatic logic [31:0] ctl(input logic [1:0] op, input logic [2:0] la,
        input logic [2:0] lb, input logic ma, input logic mb, input logic ch);
        return {21'h0, ch, op, mb, lb, ma, la};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wreq(input logic [7:0] exp);
        int k;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (ctrl_request !== exp && k < 16);
        chk({24'h0, ctrl_request}, {24'h0, exp});
    endtask

    task automatic pin(input int i, input logic v);
        @(posedge pclk);
        req_on[i] <= v;
    endtask

    task automatic pulse0(input logic [7:0] exp);
        pin(0, 1'b1);
        wreq(exp);
        pin(0, 1'b0);
        wreq(8'h00);
    endtask

    task automatic conclude();
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'hD04C395A));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) rdchk(8'(a), 32'h0);
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        chk({31'h0, e}, 32'h1);
        rdchk(8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        repeat (3) begin
            d = $urandom;
            apb(1'b1, 8'h08, d);
            rdchk(8'h08, d & 32'hFF);
            apb(1'b1, 8'h00, d & 32'h7F7);
            rdchk(8'h00, d & 32'h7F7);
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        // Normal mode on random lines, memory and I/O mapped.
        repeat (6) begin
            n = $urandom % 8;
            d = ($urandom % 2) << n;
            io_map <= d[7:0];
            apb(1'b1, 8'h08, d);
            pin(n, 1'b1);
            wreq(8'h01 << n);
            if (d != 0) wreq(8'h00);
            pin(n, 1'b0);
            wreq(8'h00);
        end
        // Bypassed line holds through service.
        io_map <= 8'h08;
        apb(1'b1, 8'h08, 32'h08);
        apb(1'b1, 8'h04, 32'h08);
        pin(3, 1'b1);
        wreq(8'h08);
        repeat (8) @(posedge pclk);
        wreq(8'h08);
        pin(3, 1'b0);
        wreq(8'h00);
        apb(1'b1, 8'h04, 32'h0);
        io_map <= 8'h00;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, ctl(2'h0, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0));
        for (int i = 0; i < 5; i++) pulse0(8'h01 << (i % 4));
        rdchk(8'h0C, 32'h100);
        apb(1'b1, 8'h00, ctl(2'h3, 3'h1, 3'h0, 1'b0, 1'b0, 1'b0));
        apb(1'b1, 8'h00, ctl(2'h0, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0));
        pulse0(8'h02);
        apb(1'b1, 8'h00, ctl(2'h3, 3'h0, 3'h1, 1'b0, 1'b0, 1'b0));
        apb(1'b1, 8'h00, ctl(2'h0, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0));
        pulse0(8'h01);
        // Parallel fan-out, chained and on circuit B alone.
        io_map <= 8'hFF;
        apb(1'b1, 8'h08, 32'hFF);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, ctl(2'h0, pa[i], pb[i], 1'b1, 1'b1, pc[i]));
            pin(pp[i], 1'b1);
            wreq(pe[i]);
            wreq(8'h00);
            pin(pp[i], 1'b0);
        end
        // Forced set and clear of every line.
        for (int i = 0; i < 8; i++) begin
            d = i < 4 ? ctl(2'h1, 3'(i), 3'h0, 1'b0, 1'b0, 1'b0)
                      : ctl(2'h1, 3'h4, 3'(i), 1'b0, 1'b0, 1'b0);
            apb(1'b1, 8'h00, d);
            wreq(8'h01 << i);
            chk({31'h0, bus_lock}, 32'h1);
            apb(1'b1, 8'h00, d ^ 32'h300);
            wreq(8'h00);
        end
        // Chained cyclic scan over all eight lines.
        io_map <= 8'h00;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, ctl(2'h3, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0));
        apb(1'b1, 8'h00, ctl(2'h0, 3'h7, 3'h7, 1'b0, 1'b0, 1'b1));
        for (int i = 0; i < 9; i++) pulse0(8'h01 << (i % 8));
        rdchk(8'h0C, 32'h1100);
        apb(1'b1, 8'h00, 32'h0);
        repeat (3) @(posedge pclk);
        chk({31'h0, bus_lock}, 32'h0);
        conclude();
    end
endmodule // testbench

`default_nettype wire
